//--- vic_pkg.sv
// Package for the vectored interrupt controller: register offsets, field layout, reset values.
// Assumes a 32-bit APB register port with 12-bit offsets inside the block's window.
package vic_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned CHANNELS    = 32;
  localparam int unsigned LEVEL_W     = 3;
  localparam int unsigned STACK_DEPTH = 8;
  localparam logic [31:0] BASE_ADDR   = 32'hFFFFF000;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [11:0] OFF_ENABLE      = 12'h000;
  localparam logic [11:0] OFF_ENABLE_SET  = 12'h004;
  localparam logic [11:0] OFF_ENABLE_CLR  = 12'h008;
  localparam logic [11:0] OFF_FALLBACK    = 12'h00C;
  localparam logic [11:0] OFF_MASKED_STAT = 12'h010;
  localparam logic [11:0] OFF_RAW_STAT    = 12'h014;
  localparam logic [11:0] OFF_NORMAL_DBG  = 12'h018;
  localparam logic [11:0] OFF_FAST_DBG    = 12'h01C;
  localparam logic [11:0] OFF_SOFT_REQ    = 12'h020;
  localparam logic [11:0] OFF_SOFT_SET    = 12'h024;
  localparam logic [11:0] OFF_SOFT_CLR    = 12'h028;
  localparam logic [11:0] OFF_VECTOR_BASE = 12'h080;
  localparam logic [11:0] OFF_CONFIG_BASE = 12'h100;
  localparam logic [11:0] OFF_NORMAL_VEC  = 12'hF00;
  localparam logic [11:0] OFF_FAST_VEC    = 12'hF04;
  localparam logic [11:0] OFF_NORMAL_END  = 12'hF08;
  localparam logic [11:0] OFF_FAST_END    = 12'hF0C;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned CFG_LEVEL_LSB  = 0;
  localparam int unsigned CFG_SELECT_BIT = 8;
  localparam int unsigned DBG_DEPTH_LSB  = 8;
  localparam logic [31:0] RESET_WORD     = 32'h00000000;

  // APB request carried as one bundle
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } vic_apb_req_t;

  // Channel configuration: line_select 1 routes to the fast line
  typedef struct packed {
    logic               line_select;
    logic [LEVEL_W-1:0] urgency_level;
  } vic_cfg_t;

endpackage

//--- vic_regbank.sv
// Per-channel storage: vector words and configuration words, indexed by channel.
// Assumes one writer port, one registered read port and an unregistered view of all words, in the bus clock domain.
`timescale 1ns/1ns
module vic_regbank #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW    = 5
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_idx,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_idx,
  output logic      [WIDTH-1:0] rd_data,
  output logic      [DEPTH*WIDTH-1:0] all_words
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ****************************************************************
  // Storage; every word is visible to the arbiter in parallel
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= '0;
      rd_data <= '0;
    end
    else if (ce)
    begin
      if (wr_en)
        mem[wr_idx] <= wr_data;
      rd_data <= mem[rd_idx];
    end
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_flat
      assign all_words[g*WIDTH +: WIDTH] = mem[g];
    end
  endgenerate

endmodule // vic_regbank

//--- vic_top.sv
// Vectored interrupt controller core: enables, soft requests, arbitration, nesting stack.
// Assumes APB signalling on one clock; vector reads answer with no wait state.
//
// Operation
// - Every channel routes to normal or fast line and owns a vector.
// - Each channel holds a priority 0 (most urgent) to 7 (least).
// - Fast channels ignore programmed priority and count as level 0.
// - Pick most urgent level first, then lowest channel number.
// - Normal and fast arbitration run independently, neither favoured.
// - Vector reads return the winning channel vector of that line.
// - With nothing active, vector reads return the fallback vector.
// - Any end-of-service write completes the routine; data is ignored.
// - While nested, only strictly more urgent requests raise the line.
// - Fast line never nests; only normal routines are preempted.
// - Normal stack is 8 deep; vector read pushes, end write pops.
// - Levels equal or less urgent than the stack top are masked.
// - Requests are not latched; line follows source and enable.
// - Block at FFFFF000h with 32 vector and 32 config registers.
// - Ones written to set or clear registers change enable or soft request bits.
// - Normal debug shows depth in bits 11:8, level in bits 2:0.
`timescale 1ns/1ns
module vic_top #(
  parameter int unsigned CHANNELS = vic_pkg::CHANNELS
) (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                ce,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [CHANNELS-1:0] src_req,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     irq_req,
  output logic                     fiq_req
);

  localparam int unsigned LW = vic_pkg::LEVEL_W;
  localparam int unsigned SD = vic_pkg::STACK_DEPTH;

  // ****************************************************************
  // Request pins: three-stage sampling, change taken when 2 and 3 agree
  // ****************************************************************
  logic [CHANNELS-1:0] sync_a;
  logic [CHANNELS-1:0] sync_b;
  logic [CHANNELS-1:0] sync_c;
  logic [CHANNELS-1:0] src_clean;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync_a    <= '0;
      sync_b    <= '0;
      sync_c    <= '0;
      src_clean <= '0;
    end
    else if (ce)
    begin
      sync_a    <= src_req;
      sync_b    <= sync_a;
      sync_c    <= sync_b;
      src_clean <= (sync_b & sync_c) | (src_clean & (sync_b | sync_c));
    end
  end

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  vic_pkg::vic_apb_req_t req;
  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

  wire setup_ph  = req.sel && !req.enable;
  wire wr_cycle  = setup_ph && req.write;
  wire rd_cycle  = setup_ph && !req.write;
  wire hit_vec   = (req.addr[11:7] == vic_pkg::OFF_VECTOR_BASE[11:7]);
  wire hit_cfg   = (req.addr[11:7] == vic_pkg::OFF_CONFIG_BASE[11:7]);
  wire [4:0] idx = req.addr[6:2];
  wire w_en      = wr_cycle && req.addr == vic_pkg::OFF_ENABLE;
  wire w_eset    = wr_cycle && req.addr == vic_pkg::OFF_ENABLE_SET;
  wire w_eclr    = wr_cycle && req.addr == vic_pkg::OFF_ENABLE_CLR;
  wire w_fb      = wr_cycle && req.addr == vic_pkg::OFF_FALLBACK;
  wire w_sw      = wr_cycle && req.addr == vic_pkg::OFF_SOFT_REQ;
  wire w_swset   = wr_cycle && req.addr == vic_pkg::OFF_SOFT_SET;
  wire w_swclr   = wr_cycle && req.addr == vic_pkg::OFF_SOFT_CLR;
  wire w_vec     = wr_cycle && hit_vec;
  wire w_cfg     = wr_cycle && hit_cfg;
  wire w_nend    = wr_cycle && req.addr == vic_pkg::OFF_NORMAL_END;
  wire w_fend    = wr_cycle && req.addr == vic_pkg::OFF_FAST_END;
  wire r_nvec    = rd_cycle && req.addr == vic_pkg::OFF_NORMAL_VEC;
  wire r_fvec    = rd_cycle && req.addr == vic_pkg::OFF_FAST_VEC;

  // ****************************************************************
  // Enable and soft request registers
  // ****************************************************************
  logic [CHANNELS-1:0] chan_enable;
  logic [CHANNELS-1:0] soft_request;
  logic [31:0]         fallback_vector;
  logic [CHANNELS-1:0] wdata_ch;
  assign wdata_ch = req.wdata[CHANNELS-1:0];

  wire [CHANNELS-1:0] next_enable =
    w_en   ? wdata_ch :
    w_eset ? (chan_enable | wdata_ch) :
    w_eclr ? (chan_enable & ~wdata_ch) : chan_enable;
  wire [CHANNELS-1:0] next_soft =
    w_sw    ? wdata_ch :
    w_swset ? (soft_request | wdata_ch) :
    w_swclr ? (soft_request & ~wdata_ch) : soft_request;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      chan_enable     <= '0;
      soft_request    <= '0;
      fallback_vector <= vic_pkg::RESET_WORD;
    end
    else if (ce)
    begin
      chan_enable  <= next_enable;
      soft_request <= next_soft;
      if (w_fb)
        fallback_vector <= req.wdata;
    end
  end

  // ****************************************************************
  // Per-channel vectors and configurations
  // ****************************************************************
  logic [32*CHANNELS-1:0] vec_flat;
  logic [32*CHANNELS-1:0] cfg_flat;
  // Read straight from the flat words: the bank's read register would lag the answer a cycle
  wire  [31:0]            vec_rd = vec_flat[idx*32 +: 32];
  wire  [31:0]            cfg_rd = cfg_flat[idx*32 +: 32];

  vic_regbank #(.WIDTH(32), .DEPTH(CHANNELS), .AW(5)) u_vectors (
    .clk       (clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .wr_en     (w_vec),
    .wr_idx    (idx),
    .wr_data   (req.wdata),
    .rd_idx    (idx),
    .rd_data   (),
    .all_words (vec_flat)
  );

  // Config words keep only level and route bits so reserved bits read zero
  wire [31:0] cfg_wmask = (32'h1 << vic_pkg::CFG_SELECT_BIT) | 32'h7;
  vic_regbank #(.WIDTH(32), .DEPTH(CHANNELS), .AW(5)) u_configs (
    .clk       (clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .wr_en     (w_cfg),
    .wr_idx    (idx),
    .wr_data   (req.wdata & cfg_wmask),
    .rd_idx    (idx),
    .rd_data   (),
    .all_words (cfg_flat)
  );

  // ****************************************************************
  // Request qualification and arbitration
  // ****************************************************************
  wire [CHANNELS-1:0] raw_req    = src_clean | soft_request;
  wire [CHANNELS-1:0] active_req = raw_req & chan_enable;

  logic [CHANNELS-1:0] is_fast;
  logic [LW-1:0]       lvl [CHANNELS];
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_cfg
      assign is_fast[g] = cfg_flat[g*32 + vic_pkg::CFG_SELECT_BIT];
      assign lvl[g]     = is_fast[g] ? '0 : cfg_flat[g*32 + vic_pkg::CFG_LEVEL_LSB +: LW];
    end
  endgenerate

  // Scan from the top so the lowest channel of the most urgent level wins
  logic          n_any;
  logic [4:0]    n_ch;
  logic [LW-1:0] n_lvl;
  logic          f_any;
  logic [4:0]    f_ch;
  always_comb
  begin
    n_any = 1'b0;
    n_ch  = '0;
    n_lvl = '1;
    f_any = 1'b0;
    f_ch  = '0;
    for (int i = CHANNELS - 1; i >= 0; i--)
    begin
      if (active_req[i] && !is_fast[i] && (!n_any || lvl[i] <= n_lvl))
      begin
        n_any = 1'b1;
        n_ch  = 5'(i);
        n_lvl = lvl[i];
      end
      if (active_req[i] && is_fast[i])
      begin
        f_any = 1'b1;
        f_ch  = 5'(i);
      end
    end
  end

  // ****************************************************************
  // Normal nesting stack and fast in-service flag
  // ****************************************************************
  logic [LW-1:0] lvl_stack [SD];
  logic [3:0]    depth;
  logic          fast_busy;

  wire [LW-1:0] top_level = (depth == 4'h0) ? '0 : lvl_stack[3'(depth - 4'h1)];
  wire n_eligible = n_any && ((depth == 4'h0) || (n_lvl < top_level));
  wire f_eligible = f_any && !fast_busy;
  wire do_push    = r_nvec && n_eligible && (depth != 4'(SD));
  wire do_pop     = w_nend && (depth != 4'h0);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < SD; i++)
        lvl_stack[i] <= '0;
      depth     <= '0;
      fast_busy <= 1'b0;
    end
    else if (ce)
    begin
      if (do_push)
      begin
        lvl_stack[3'(depth)] <= n_lvl;
        depth                <= depth + 4'h1;
      end
      else if (do_pop)
        depth <= depth - 4'h1;
      if (r_fvec && f_any)
        fast_busy <= 1'b1;
      else if (w_fend)
        fast_busy <= 1'b0;
    end
  end

  // ****************************************************************
  // Read mux, answered in the access phase
  // ****************************************************************
  wire [31:0] n_vector = n_eligible ? vec_flat[n_ch*32 +: 32] : fallback_vector;
  wire [31:0] f_vector = f_eligible ? vec_flat[f_ch*32 +: 32] : fallback_vector;
  wire [31:0] n_dbg    = {20'h0, depth, 5'h0, top_level};
  wire [31:0] f_dbg    = {23'h0, fast_busy, 8'h0};

  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0;
    if (hit_vec)
      next_rdata = vec_rd;
    else if (hit_cfg)
      next_rdata = cfg_rd;
    else
    begin
      case (req.addr)
        vic_pkg::OFF_ENABLE:      next_rdata = 32'(chan_enable);
        vic_pkg::OFF_FALLBACK:    next_rdata = fallback_vector;
        vic_pkg::OFF_MASKED_STAT: next_rdata = 32'(active_req);
        vic_pkg::OFF_RAW_STAT:    next_rdata = 32'(raw_req);
        vic_pkg::OFF_NORMAL_DBG:  next_rdata = n_dbg;
        vic_pkg::OFF_FAST_DBG:    next_rdata = f_dbg;
        vic_pkg::OFF_SOFT_REQ:    next_rdata = 32'(soft_request);
        default:                  next_rdata = 32'h0;
      endcase
    end
  end

  // Vector words are taken at setup, so the answer matches the level pushed
  wire [31:0] vec_answer = (req.addr == vic_pkg::OFF_NORMAL_VEC) ? n_vector : f_vector;

  wire hold_sel = (req.addr == vic_pkg::OFF_NORMAL_VEC) || (req.addr == vic_pkg::OFF_FAST_VEC);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prdata  <= '0;
      pready  <= 1'b0;
      irq_req <= 1'b0;
      fiq_req <= 1'b0;
    end
    else if (ce)
    begin
      pready  <= setup_ph;
      prdata  <= hold_sel ? vec_answer : next_rdata;
      irq_req <= n_eligible;
      fiq_req <= f_eligible;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_PUSH_DEPTH: assert property (@(posedge clk) disable iff (!rst_b)
    ce && do_push |=> depth == $past(depth) + 4'h1)
    else $error("stack did not grow on vector read");
  AST_POP_DEPTH: assert property (@(posedge clk) disable iff (!rst_b)
    ce && do_pop && !do_push |=> depth == $past(depth) - 4'h1)
    else $error("stack did not shrink on end write");
  AST_DEPTH_MAX: assert property (@(posedge clk) disable iff (!rst_b)
    depth <= 4'h8)
    else $error("stack overflow");
  AST_MASK_LEVEL: assert property (@(posedge clk) disable iff (!rst_b)
    depth != 4'h0 && n_lvl >= top_level |-> !n_eligible)
    else $error("masked level reached the line");
  AST_IRQ_FOLLOW: assert property (@(posedge clk) disable iff (!rst_b)
    ce && !n_any |=> !irq_req)
    else $error("normal line held without request");
  AST_FIQ_FOLLOW: assert property (@(posedge clk) disable iff (!rst_b)
    ce && !f_any |=> !fiq_req)
    else $error("fast line held without request");
  AST_FALLBACK: assert property (@(posedge clk) disable iff (!rst_b)
    ce && r_nvec && !n_eligible |=> prdata == $past(fallback_vector))
    else $error("fallback vector not returned");
  AST_FAST_LEVEL: assert property (@(posedge clk) disable iff (!rst_b)
    is_fast[0] |-> lvl[0] == 3'h0)
    else $error("fast channel priority not zero");
  AST_ENABLE_SET: assert property (@(posedge clk) disable iff (!rst_b)
    ce && w_eset |=> chan_enable == ($past(chan_enable) | $past(wdata_ch)))
    else $error("enable set failed");
  AST_FAST_NO_NEST: assert property (@(posedge clk) disable iff (!rst_b)
    ce && fast_busy |=> !fiq_req)
    else $error("fast line raised while fast routine in service");
  AST_NORMAL_VECTOR: assert property (@(posedge clk) disable iff (!rst_b)
    ce && r_nvec && n_eligible |=> prdata == $past(vec_flat[n_ch*32 +: 32]))
    else $error("normal vector read returned wrong channel vector");

endmodule // vic_top

//--- vic_core_model.sv
// Processor core stand-in: samples both interrupt lines and counts entries.
// Assumes the lines are registered in the same clock domain as the core.
`timescale 1ns/1ns
module vic_core_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       irq_req,
  input  wire logic       fiq_req,
  output logic      [7:0] irq_entries,
  output logic      [7:0] fiq_entries
);
  logic irq_d;
  logic fiq_d;

  // A rise is one exception entry; the service routine itself runs in the bench
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_d       <= 1'b0;
      fiq_d       <= 1'b0;
      irq_entries <= 8'h00;
      fiq_entries <= 8'h00;
    end
    else
    begin
      irq_d <= irq_req;
      fiq_d <= fiq_req;
      if (irq_req && !irq_d)
        irq_entries <= irq_entries + 8'h01;
      if (fiq_req && !fiq_d)
        fiq_entries <= fiq_entries + 8'h01;
    end
  end
endmodule // vic_core_model

//--- vic_top_test.sv
// Self-checking bench for the vectored interrupt controller.
// Assumes the zero-wait-state register port and about 5 cycles of request latency.
`timescale 1ns/1ns
module vic_top_test;
  logic                 clk;
  logic                 rst_b;
  vic_pkg::vic_apb_req_t req;
  logic [31:0]          src_req;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 irq_req;
  logic                 fiq_req;
  logic [7:0]           irq_entries;
  logic [7:0]           fiq_entries;
  logic                 ce;
  logic [31:0]          exp_q[$];
  logic [31:0]          vecs[32];
  logic [31:0]          rnd;
  logic [31:0]          fb;
  logic [7:0]           e0;
  logic [11:0]          offs[9];
  int                   n_errors;
  int                   checked;
  int                   cycles;

  vic_top dut (.clk(clk), .rst_b(rst_b), .ce(ce), .psel(req.sel), .penable(req.enable),
    .pwrite(req.write), .paddr(req.addr), .pwdata(req.wdata), .src_req(src_req),
    .prdata(prdata), .pready(pready), .irq_req(irq_req), .fiq_req(fiq_req));

  vic_core_model core (.clk(clk), .rst_b(rst_b), .irq_req(irq_req), .fiq_req(fiq_req),
    .irq_entries(irq_entries), .fiq_entries(fiq_entries));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Fast channels 23 and 25 get opposite urgency to expose any use of it
  function automatic logic [31:0] cfg_of(input int i);
    return {23'h000000, (i == 23 || i == 25), 5'h00, 3'(i % 8)};
  endfunction

  task automatic stop_test();
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held from setup until pready is sampled high
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req = '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    #1 req.enable = 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    if (n == 8)
      check(32'h0, 32'h1);
    #1 req.sel = 1'b0;
    req.enable = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // Lines are sampled once the request path has settled
  task automatic lines(input logic ei, input logic ef);
    repeat (8) @(posedge clk);
    #1;
    check({31'h0, irq_req}, {31'h0, ei});
    check({31'h0, fiq_req}, {31'h0, ef});
  endtask

  always @(posedge clk)
  begin
    if (req.sel && req.enable && !req.write && pready === 1'b1)
    begin
      if (exp_q.size() > 0)
        check(prdata, exp_q.pop_front());
      else
        check(prdata, 32'hFFFFFFFF);
    end
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_errors++;
      stop_test();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    n_errors = 0;
    checked = 0;
    cycles = 0;
    rst_b = 1'b0;
    ce = 1'b1;
    src_req = 32'h0;
    req = '0;
    rnd = 32'h00000054;
    offs = '{12'h000, 12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C, 12'h020, 12'h030,
      12'hF00};
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    foreach (offs[i]) rd(offs[i], vic_pkg::RESET_WORD);
    for (int i = 0; i < 32; i++)
    begin
      rnd = lfsr_next(rnd);
      vecs[i] = rnd;
      wr(12'h080 + 12'(4 * i), rnd);
      wr(12'h100 + 12'(4 * i), cfg_of(i));
    end
    for (int i = 0; i < 32; i++)
    begin
      rd(12'h080 + 12'(4 * i), vecs[i]);
      rd(12'h100 + 12'(4 * i), cfg_of(i));
    end
    fb = lfsr_next(rnd);
    wr(12'h00C, fb);
    rd(12'hF00, fb);
    rd(12'hF04, fb);
    wr(12'h000, 32'h0);
    wr(12'h004, 32'h000000F0);
    wr(12'h008, 32'h00000030);
    rd(12'h000, 32'h000000C0);
    rnd = lfsr_next(fb);
    wr(12'h000, 32'h0000FFFF);
    #1 src_req = rnd & 32'h7FFFFFFF;
    repeat (8) @(posedge clk);
    #1;
    rd(12'h010, rnd & 32'h0000FFFF);
    rd(12'h014, rnd & 32'h7FFFFFFF);
    src_req = 32'h0;
    wr(12'h000, 32'h80000000);
    wr(12'h024, 32'h80000000);
    rd(12'h020, 32'h80000000);
    lines(1'b1, 1'b0);
    wr(12'h028, 32'h80000000);
    lines(1'b0, 1'b0);
    // Nest down through all eight levels, then unwind
    wr(12'h000, 32'hFFFFFFFF);
    e0 = irq_entries;
    for (int k = 7; k >= 0; k--)
    begin
      src_req[k] = 1'b1;
      lines(1'b1, 1'b0);
      rd(12'hF00, vecs[k]);
      rd(12'h018, {20'h0, 4'(8 - k), 5'h0, 3'(k)});
      lines(1'b0, 1'b0);
    end
    check({24'h0, irq_entries - e0}, 32'h8);
    for (int j = 1; j <= 8; j++)
    begin
      wr(12'hF08, lfsr_next(rnd));
      rd(12'h018, {20'h0, 4'(8 - j), 5'h0, 3'(j % 8)});
    end
    #1 src_req = 32'h00002808;
    lines(1'b1, 1'b0);
    rd(12'hF00, vecs[3]);
    wr(12'hF08, 32'h0);
    src_req[3] = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    rd(12'hF00, vecs[11]);
    wr(12'hF08, 32'h0);
    src_req = 32'h02800000;
    lines(1'b0, 1'b1);
    rd(12'hF04, vecs[23]);
    rd(12'h01C, 32'h00000100);
    src_req[4] = 1'b1;
    lines(1'b1, 1'b0);
    wr(12'hF0C, lfsr_next(rnd));
    rd(12'h01C, 32'h0);
    src_req = 32'h00000010;
    lines(1'b1, 1'b0);
    wr(12'h008, 32'h00000010);
    lines(1'b0, 1'b0);
    wr(12'h004, 32'h00000010);
    lines(1'b1, 1'b0);
    // Clock enable low freezes the synchronisers and the line with them
    ce = 1'b0;
    src_req = 32'h0;
    lines(1'b1, 1'b0);
    ce = 1'b1;
    lines(1'b0, 1'b0);
    check({24'h0, fiq_entries}, 32'h2);
    stop_test();
  end
endmodule // vic_top_test
